// ---- hdl/dtgr_defines.svh ----
// Register offsets, reset values and field positions of the trim and pin register bank
`ifndef DTGR_DEFINES_SVH
`define DTGR_DEFINES_SVH

// Register offsets on the 5-bit register address
`define DTGR_ADDR_PIN      5'h01
`define DTGR_ADDR_SLEEP    5'h02
`define DTGR_ADDR_OFS_A    5'h03
`define DTGR_ADDR_OFS_B    5'h04
`define DTGR_ADDR_BCAST    5'h07
`define DTGR_ADDR_IN_BASE  5'h08
`define DTGR_ADDR_ZERO_BASE 5'h10
`define DTGR_ADDR_GAIN_BASE 5'h18

// Reset values
`define DTGR_RST_PIN       16'he000
`define DTGR_RST_SLEEP     16'h0000
`define DTGR_RST_DATA      16'h0000
`define DTGR_RST_ZERO      16'h0000
`define DTGR_RST_GAIN      16'h8000
`define DTGR_OFS_SINGLE    16'h0000
`define DTGR_OFS_GAIN6     16'h999a
`define DTGR_OFS_GAIN4     16'haaab

// Field positions
`define DTGR_PIN_MSB       15
`define DTGR_PIN_LSB       13
`define DTGR_SLEEP_BIT     15

// Gain coefficient offset: code 0000h means one half
`define DTGR_GAIN_HALF     17'h08000

`endif

// ---- hdl/dtgr_pkg.sv ----
// Types shared by the trim and pin register bank
package dtgr_pkg;

    typedef logic [15:0] dtgr_word_t;
    typedef logic [2:0]  dtgr_chan_t;

    // One register access from the serial frame decoder
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [4:0] addr;
        dtgr_word_t wdata;
    } dtgr_req_s;

endpackage

// ---- hdl/dtgr_corr.sv ----
// Correction engine: gain multiply, signed zero trim and clamp
`timescale 1ns/10ps
`include "dtgr_defines.svh"
module dtgr_corr
(
    input  wire logic [15:0] code,
    input  wire logic [15:0] gain,
    input  wire logic [15:0] zero,
    output logic      [15:0] result
);

    logic        [16:0] gain_full;
    logic        [32:0] prod;
    logic        [16:0] scaled;
    logic signed [18:0] sum;

    // Coefficient is (32768 + gain) / 65536, so 0.5 up to just under 1.5
    assign gain_full = {1'b0, gain} + `DTGR_GAIN_HALF;
    assign prod      = {17'h00000, code} * {16'h0000, gain_full};
    assign scaled    = prod[32:16];
    assign sum       = $signed({2'b00, scaled}) + $signed({{3{zero[15]}}, zero});

    // RULE_18: clamp to code range
    assign result = sum[18] ? 16'h0000 : ((sum[17:16] != 2'b00) ? 16'hffff : sum[15:0]);

endmodule

// ---- hdl/dtgr_sleep.sv ----
// Serial sleep control, select-edge wake and input shift or bypass path
`timescale 1ns/10ps
`include "dtgr_defines.svh"
module dtgr_sleep
(
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic sleep_wr,
    input  wire logic sleep_wbit,
    input  wire logic wake_n,
    input  wire logic cs_n,
    input  wire logic sclk_fall,
    input  wire logic edge_wake_en,
    input  wire logic sdi,
    output logic      sleep,
    output logic      sdo
);

    logic        cs_q;
    logic [1:0]  fall_cnt;
    logic [15:0] shift;
    logic        cs_rise;
    logic        edge_wake;
    logic        next_sleep;

    // Reset word named so its sleep field can be selected
    localparam logic [15:0] SLEEP_RESET_WORD = `DTGR_RST_SLEEP;

    // Falls are counted only up to two; more never matters
    assign cs_rise = cs_n & ~cs_q;
    // RULE_17: select edge wake
    assign edge_wake = cs_rise & edge_wake_en & wake_n & (fall_cnt <= 2'd1);
    // RULE_08: wake pin clears
    assign next_sleep = !wake_n ? 1'b0 : (edge_wake ? 1'b0 : (sleep_wr ? sleep_wbit : sleep));

    // Sleep flag and select tracking
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            sleep    <= SLEEP_RESET_WORD[`DTGR_SLEEP_BIT];
            cs_q     <= 1'b1;
            fall_cnt <= 2'd0;
        end
        else
        begin
            sleep    <= next_sleep;
            cs_q     <= cs_n;
            fall_cnt <= cs_n ? 2'd0 : ((sclk_fall && fall_cnt != 2'd2) ? fall_cnt + 2'd1 : fall_cnt);
        end
    end

    // RULE_09: shift or bypass
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            shift <= 16'h0000;
            sdo   <= 1'b0;
        end
        else
        begin
            if (!sleep && !cs_n && sclk_fall)
                shift <= {shift[14:0], sdi};
            sdo <= sleep ? sdi : shift[15];
        end
    end

    sequence s_busy_frame_end;
        sleep && wake_n && cs_rise && edge_wake_en && fall_cnt == 2'd2 && !sleep_wr;
    endsequence

    property p_sleep_set;
        @(posedge clk) disable iff (!resetn)
        sleep_wr && sleep_wbit && wake_n && !cs_rise |=> sleep;
    endproperty
    a_sleep_set: assert property (p_sleep_set) else $error("sleep bit not set"); // RULE_07

    property p_bypass;
        @(posedge clk) disable iff (!resetn)
        sleep |=> sdo == $past(sdi);
    endproperty
    a_bypass: assert property (p_bypass) else $error("sleep bypass broken"); // RULE_09

    property p_no_busy_wake;
        @(posedge clk) disable iff (!resetn)
        s_busy_frame_end |=> sleep;
    endproperty
    a_no_busy_wake: assert property (p_no_busy_wake) else $error("woke after many falls"); // RULE_17

endmodule

// ---- hdl/dtgr_top.sv ----
// Pin control, offset code, serial sleep and per-channel trim register bank
`timescale 1ns/10ps
`include "dtgr_defines.svh"

// Functional notes
// RULE_01: Each pin bit written one releases its open-drain pin; zero pulls low.
// RULE_02: Reading pin bits returns the sampled level of each pin.
// RULE_03: After any reset all three pin bits are one, register reads E000h.
// RULE_04: Dual supply: offset code defaults to its group's trimmed code for the span.
// RULE_05: Single supply: offset writes ignored, offset reads return 0000h.
// RULE_06: Dual supply: span change reloads that group's trimmed offset code.
// RULE_07: Sleep bit one puts serial interface in sleep; reset value 0000h.
// RULE_08: Sleep bit clears on reset pin and while wake pin is low.
// RULE_09: Normal mode shifts input; sleep mode passes input straight to output.
// RULE_10: Broadcast write loads all eight data registers, only with correction disabled.
// RULE_11: Broadcast address always reads 0000h.
// RULE_12: Correction on: data to input register; off: straight to data register.
// RULE_13: Output changes only on latch load; input registers reset to 0000h.
// RULE_14: Zero trim is signed 16-bit offset, one LSB per step, resets 0000h.
// RULE_15: Gain trim is straight binary coefficient 0.5 to 1.5, resets 8000h.
// RULE_16: Span bit zero selects six times reference, one selects four times.
// RULE_17: Select edge wakes only if at most one clock fall while selected.
// RULE_18: Correction multiplies by gain, adds zero trim, clamps to code range.
module dtgr_top
#(
    parameter logic [15:0] TRIM_A_GAIN6 = `DTGR_OFS_GAIN6,
    parameter logic [15:0] TRIM_A_GAIN4 = `DTGR_OFS_GAIN4,
    parameter logic [15:0] TRIM_B_GAIN6 = `DTGR_OFS_GAIN6,
    parameter logic [15:0] TRIM_B_GAIN4 = `DTGR_OFS_GAIN4
)
(
    input  wire logic              CLK_SYS,
    input  wire logic              RESETN,
    input  wire dtgr_pkg::dtgr_req_s REG_REQ,
    output logic [15:0]            REG_RDATA,
    input  wire logic              CORRECTION_ENABLE,
    input  wire logic              SPAN_SEL_A,
    input  wire logic              SPAN_SEL_B,
    input  wire logic              SINGLE_SUPPLY,
    input  wire logic              SELECT_EDGE_WAKE_ENABLE,
    input  wire logic              LATCH_LOAD,
    output logic [7:0][15:0]       CHANNEL_CODE,
    output logic [15:0]            OFFSET_CODE_A,
    output logic [15:0]            OFFSET_CODE_B,
    input  wire logic [2:0]        PIN_IN,
    output logic [2:0]             PIN_OUT,
    output logic [2:0]             PIN_OEN,
    input  wire logic              WAKE_REQUEST_PIN_N,
    input  wire logic              CS_N,
    input  wire logic              SCLK_FALL,
    input  wire logic              SDI,
    output logic                   SDO,
    output logic                   SLEEP_MODE
);

    // Window decode on the upper address bits, reused for three register arrays
    function automatic logic win_hit(input logic [4:0] addr, input logic [4:0] base);
        win_hit = (addr[4:3] == base[4:3]);
    endfunction

    dtgr_pkg::dtgr_word_t in_reg   [8];
    dtgr_pkg::dtgr_word_t data_reg [8];
    dtgr_pkg::dtgr_word_t zero_reg [8];
    dtgr_pkg::dtgr_word_t gain_reg [8];
    logic [2:0]           pin_smp;
    logic [1:0]           span_q;
    logic                 corr_pend;
    dtgr_pkg::dtgr_chan_t pend_ch;
    dtgr_pkg::dtgr_chan_t idx;
    dtgr_pkg::dtgr_word_t corr_out;
    dtgr_pkg::dtgr_word_t next_rdata;
    dtgr_pkg::dtgr_word_t chan_rd;
    logic                 wr_pin;
    logic                 wr_sleep;
    logic                 wr_bcast;
    logic                 wr_in;
    logic                 wr_zero;
    logic                 wr_gain;
    logic [1:0]           wr_ofs;
    logic [1:0]           span_now;
    logic [1:0]           span_chg;
    logic [15:0]          trim_sel [2];

    // Reset word named so its pin field can be selected
    localparam logic [15:0] PIN_RESET_WORD = `DTGR_RST_PIN;

    // Write strobes
    assign idx      = REG_REQ.addr[2:0];
    assign wr_pin   = REG_REQ.wr && REG_REQ.addr == `DTGR_ADDR_PIN;
    assign wr_sleep = REG_REQ.wr && REG_REQ.addr == `DTGR_ADDR_SLEEP;
    assign wr_bcast = REG_REQ.wr && REG_REQ.addr == `DTGR_ADDR_BCAST;
    assign wr_in    = REG_REQ.wr && win_hit(REG_REQ.addr, `DTGR_ADDR_IN_BASE);
    assign wr_zero  = REG_REQ.wr && win_hit(REG_REQ.addr, `DTGR_ADDR_ZERO_BASE);
    assign wr_gain  = REG_REQ.wr && win_hit(REG_REQ.addr, `DTGR_ADDR_GAIN_BASE);
    assign wr_ofs[0] = REG_REQ.wr && REG_REQ.addr == `DTGR_ADDR_OFS_A;
    assign wr_ofs[1] = REG_REQ.wr && REG_REQ.addr == `DTGR_ADDR_OFS_B;

    // RULE_16: span bit picks trim
    assign span_now    = {SPAN_SEL_B, SPAN_SEL_A};
    assign span_chg    = span_now ^ span_q;
    assign trim_sel[0] = SPAN_SEL_A ? TRIM_A_GAIN4 : TRIM_A_GAIN6;
    assign trim_sel[1] = SPAN_SEL_B ? TRIM_B_GAIN4 : TRIM_B_GAIN6;

    // Channel readback follows where written data lands
    assign chan_rd = CORRECTION_ENABLE ? in_reg[idx] : data_reg[idx];

    // RULE_02: pin readback; RULE_11: broadcast reads zero
    assign next_rdata =
        (REG_REQ.addr == `DTGR_ADDR_PIN)   ? {pin_smp, 13'h0000} :
        (REG_REQ.addr == `DTGR_ADDR_SLEEP) ? {SLEEP_MODE, 15'h0000} :
        (REG_REQ.addr == `DTGR_ADDR_OFS_A) ? OFFSET_CODE_A :
        (REG_REQ.addr == `DTGR_ADDR_OFS_B) ? OFFSET_CODE_B :
        win_hit(REG_REQ.addr, `DTGR_ADDR_IN_BASE)   ? chan_rd :
        win_hit(REG_REQ.addr, `DTGR_ADDR_ZERO_BASE) ? zero_reg[idx] :
        win_hit(REG_REQ.addr, `DTGR_ADDR_GAIN_BASE) ? gain_reg[idx] :
        16'h0000;

    // Read data holds until the next read
    always_ff @(posedge CLK_SYS)
    begin
        if (!RESETN)
            REG_RDATA <= 16'h0000;
        else if (REG_REQ.rd)
            REG_RDATA <= next_rdata;
    end

    // RULE_01: open-drain drive
    // RULE_03: pins released at reset
    always_ff @(posedge CLK_SYS)
    begin
        if (!RESETN)
        begin
            PIN_OEN <= PIN_RESET_WORD[`DTGR_PIN_MSB:`DTGR_PIN_LSB];
            PIN_OUT <= 3'h0;
            pin_smp <= 3'h7;
        end
        else
        begin
            if (wr_pin)
                PIN_OEN <= REG_REQ.wdata[`DTGR_PIN_MSB:`DTGR_PIN_LSB];
            PIN_OUT <= 3'h0;        // Only ever pulls low; pull-up is external
            pin_smp <= PIN_IN;
        end
    end

    // RULE_04: trimmed default
    // RULE_05: single supply forces zero
    // RULE_06: span change reloads
    always_ff @(posedge CLK_SYS)
    begin
        if (!RESETN)
        begin
            OFFSET_CODE_A <= TRIM_A_GAIN6;
            OFFSET_CODE_B <= TRIM_B_GAIN6;
            span_q        <= 2'b00;
        end
        else
        begin
            span_q <= span_now;
            if (SINGLE_SUPPLY)
                OFFSET_CODE_A <= `DTGR_OFS_SINGLE;
            else if (span_chg[0])
                OFFSET_CODE_A <= trim_sel[0];
            else if (wr_ofs[0])
                OFFSET_CODE_A <= REG_REQ.wdata;
            if (SINGLE_SUPPLY)
                OFFSET_CODE_B <= `DTGR_OFS_SINGLE;
            else if (span_chg[1])
                OFFSET_CODE_B <= trim_sel[1];
            else if (wr_ofs[1])
                OFFSET_CODE_B <= REG_REQ.wdata;
        end
    end

    // Correction runs one cycle after the input register is written, one channel at a time
    always_ff @(posedge CLK_SYS)
    begin
        if (!RESETN)
        begin
            corr_pend <= 1'b0;
            pend_ch   <= 3'h0;
        end
        else
        begin
            corr_pend <= wr_in && CORRECTION_ENABLE;
            pend_ch   <= idx;
        end
    end

    // RULE_18: shared engine
    dtgr_corr u_corr
    (
        .code   (in_reg[pend_ch]),
        .gain   (gain_reg[pend_ch]),
        .zero   (zero_reg[pend_ch]),
        .result (corr_out)
    );

    // Per-channel register sets
    genvar ch;
    generate
        for (ch = 0; ch < 8; ch++)
        begin : g_chan
            logic hit;
            assign hit = (idx == 3'(ch));

            // RULE_12: data routing
            // RULE_10: broadcast load
            always_ff @(posedge CLK_SYS)
            begin
                if (!RESETN)
                begin
                    in_reg[ch]   <= `DTGR_RST_DATA;
                    data_reg[ch] <= `DTGR_RST_DATA;
                end
                else
                begin
                    if (wr_in && hit && CORRECTION_ENABLE)
                        in_reg[ch] <= REG_REQ.wdata;
                    if (!CORRECTION_ENABLE && (wr_bcast || (wr_in && hit)))
                        data_reg[ch] <= REG_REQ.wdata;
                    else if (corr_pend && pend_ch == 3'(ch))
                        data_reg[ch] <= corr_out;
                end
            end

            // RULE_14: zero trim; RULE_15: gain trim
            always_ff @(posedge CLK_SYS)
            begin
                if (!RESETN)
                begin
                    zero_reg[ch] <= `DTGR_RST_ZERO;
                    gain_reg[ch] <= `DTGR_RST_GAIN;
                end
                else
                begin
                    if (wr_zero && hit)
                        zero_reg[ch] <= REG_REQ.wdata;
                    if (wr_gain && hit)
                        gain_reg[ch] <= REG_REQ.wdata;
                end
            end

            // RULE_13: latch on load
            always_ff @(posedge CLK_SYS)
            begin
                if (!RESETN)
                    CHANNEL_CODE[ch] <= `DTGR_RST_DATA;
                else if (LATCH_LOAD)
                    CHANNEL_CODE[ch] <= data_reg[ch];
            end
        end
    endgenerate

    // RULE_07: sleep register
    // RULE_09: serial path
    dtgr_sleep u_sleep
    (
        .clk          (CLK_SYS),
        .resetn       (RESETN),
        .sleep_wr     (wr_sleep),
        .sleep_wbit   (REG_REQ.wdata[`DTGR_SLEEP_BIT]),
        .wake_n       (WAKE_REQUEST_PIN_N),
        .cs_n         (CS_N),
        .sclk_fall    (SCLK_FALL),
        .edge_wake_en (SELECT_EDGE_WAKE_ENABLE),
        .sdi          (SDI),
        .sleep        (SLEEP_MODE),
        .sdo          (SDO)
    );

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESETN);

    property p_pin_drive;
        wr_pin |=> PIN_OEN == $past(REG_REQ.wdata[15:13]);
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("pin drive mismatch"); // RULE_01

    property p_pin_read;
        REG_REQ.rd && REG_REQ.addr == `DTGR_ADDR_PIN ##1 1'b1 |-> REG_RDATA[15:13] == $past(PIN_IN, 2);
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin read mismatch"); // RULE_02

    property p_reset_pins;
        disable iff (1'b0) !RESETN |=> PIN_OEN == 3'h7 && CHANNEL_CODE[0] == 16'h0000;
    endproperty
    a_reset_pins: assert property (p_reset_pins) else $error("reset values wrong"); // RULE_03

    property p_span_reload;
        !SINGLE_SUPPLY && $changed(SPAN_SEL_A) |=> OFFSET_CODE_A == $past(trim_sel[0]);
    endproperty
    a_span_reload: assert property (p_span_reload) else $error("offset not reloaded"); // RULE_06

    property p_single;
        SINGLE_SUPPLY |=> OFFSET_CODE_A == 16'h0000 && OFFSET_CODE_B == 16'h0000;
    endproperty
    a_single: assert property (p_single) else $error("offset not zero"); // RULE_05

    property p_wake_pin;
        !WAKE_REQUEST_PIN_N |=> !SLEEP_MODE;
    endproperty
    a_wake_pin: assert property (p_wake_pin) else $error("sleep held with wake low"); // RULE_08

    property p_bcast;
        wr_bcast && !CORRECTION_ENABLE |=>
            data_reg[0] == $past(REG_REQ.wdata) && data_reg[7] == $past(REG_REQ.wdata);
    endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast not loaded"); // RULE_10

    property p_bcast_read;
        REG_REQ.rd && REG_REQ.addr == `DTGR_ADDR_BCAST |=> REG_RDATA == 16'h0000;
    endproperty
    a_bcast_read: assert property (p_bcast_read) else $error("broadcast read nonzero"); // RULE_11

    sequence s_corr_write;
        wr_in && CORRECTION_ENABLE && idx == 3'h0 && !wr_bcast;
    endsequence

    property p_corr_path;
        s_corr_write ##1 !(REG_REQ.wr && !CORRECTION_ENABLE) |=> data_reg[0] == $past(corr_out);
    endproperty
    a_corr_path: assert property (p_corr_path) else $error("corrected data lost"); // RULE_12

    property p_latch_hold;
        !LATCH_LOAD |=> $stable(CHANNEL_CODE);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("output moved without load"); // RULE_13

endmodule

// ---- dv/dtgr_pin_model.sv ----
// Open-drain pin model: pull-up on each pin, optional external pull-down
`timescale 1ns/10ps
module dtgr_pin_model
(
    input  wire logic [2:0] pin_oen,
    input  wire logic [2:0] ext_low,
    output logic      [2:0] pin_level
);
    // open-drain wire level
    // Released pins float up; a driven pin or an outside pull-down wins
    assign pin_level = pin_oen & ~ext_low;
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for the trim and pin register bank
`timescale 1ns/10ps
`include "dtgr_defines.svh"
module tb_top;
    logic                clk_sys;
    logic                resetn;
    dtgr_pkg::dtgr_req_s req;
    logic [15:0]         rdata;
    logic                ce;
    logic                span_a;
    logic                span_b;
    logic                single;
    logic                edge_en;
    logic                latch;
    logic [7:0][15:0]    chan;
    logic [15:0]         ofs_a;
    logic [15:0]         ofs_b;
    logic [2:0]          pin_in;
    logic [2:0]          pin_out;
    logic [2:0]          pin_oen;
    logic [2:0]          ext_low;
    logic                wake_n;
    logic                cs_n;
    logic                sclk_fall;
    logic                sdi;
    logic                sdo;
    logic                sleep;
    int                  err_count;
    int                  checked;
    int                  cycles;
    logic [15:0]         exp_ch [8];

    dtgr_top dut
    (
        .CLK_SYS                 (clk_sys),
        .RESETN                  (resetn),
        .REG_REQ                 (req),
        .REG_RDATA               (rdata),
        .CORRECTION_ENABLE       (ce),
        .SPAN_SEL_A              (span_a),
        .SPAN_SEL_B              (span_b),
        .SINGLE_SUPPLY           (single),
        .SELECT_EDGE_WAKE_ENABLE (edge_en),
        .LATCH_LOAD              (latch),
        .CHANNEL_CODE            (chan),
        .OFFSET_CODE_A           (ofs_a),
        .OFFSET_CODE_B           (ofs_b),
        .PIN_IN                  (pin_in),
        .PIN_OUT                 (pin_out),
        .PIN_OEN                 (pin_oen),
        .WAKE_REQUEST_PIN_N      (wake_n),
        .CS_N                    (cs_n),
        .SCLK_FALL               (sclk_fall),
        .SDI                     (sdi),
        .SDO                     (sdo),
        .SLEEP_MODE              (sleep)
    );

    dtgr_pin_model pins
    (
        .pin_oen   (pin_oen),
        .ext_low   (ext_low),
        .pin_level (pin_in)
    );

    // Free-running system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Expected corrected code, clamped to the code range
    function automatic logic [15:0] corr(input logic [15:0] c, input logic [15:0] g,
                                         input logic [15:0] z);
        longint s;
        s = ((longint'(c) * (32768 + longint'(g))) >>> 16) + longint'($signed(z));
        if (s < 0)
            return 16'h0000;
        if (s > 65535)
            return 16'hffff;
        return s[15:0];
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle request pulses; release one edge later
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        req <= '0;
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk_sys);
        req <= '0;
        #1 chk(rdata, e);
    endtask

    task automatic latch_pulse;
        @(posedge clk_sys);
        latch <= 1'b1;
        @(posedge clk_sys);
        latch <= 1'b0;
        #1;
    endtask

    task automatic chk_all;
        for (int i = 0; i < 8; i++)
            chk(chan[i], exp_ch[i]);
    endtask

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Hang guard: the whole sequence needs well under this many cycles
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            err_count++;
            wrap_up();
        end
    end

    initial
    begin
        logic [15:0] v;
        logic [15:0] g;
        logic [15:0] z;
        resetn = 1'b0;
        req = '0;
        ce = 1'b0;
        span_a = 1'b0;
        span_b = 1'b0;
        single = 1'b0;
        edge_en = 1'b0;
        latch = 1'b0;
        ext_low = 3'h0;
        wake_n = 1'b1;
        cs_n = 1'b1;
        sclk_fall = 1'b0;
        sdi = 1'b0;
        void'($urandom(29));
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        // Reset values of pin, sleep, offset, data, zero and gain registers
        rdchk(`DTGR_ADDR_PIN, 16'he000);
        chk({13'h0, pin_oen}, 16'h0007);
        rdchk(`DTGR_ADDR_SLEEP, 16'h0000);
        rdchk(`DTGR_ADDR_OFS_A, 16'h999a);
        rdchk(`DTGR_ADDR_OFS_B, 16'h999a);
        rdchk(5'h05, 16'h0000);
        for (int i = 0; i < 8; i++)
        begin
            rdchk(`DTGR_ADDR_IN_BASE + 5'(i), 16'h0000);
            rdchk(`DTGR_ADDR_ZERO_BASE + 5'(i), 16'h0000);
            rdchk(`DTGR_ADDR_GAIN_BASE + 5'(i), 16'h8000);
            exp_ch[i] = 16'h0000;
        end
        // Deselected in normal mode: input must not reach the output
        @(posedge clk_sys);
        sdi <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1 chk({15'h0, sdo}, 16'h0000);
        // Pin drive and readback, outside pull-downs at random
        for (int k = 0; k < 6; k++)
        begin
            v = 16'($urandom());
            @(posedge clk_sys);
            ext_low <= 3'($urandom());
            wr(`DTGR_ADDR_PIN, v);
            repeat (2) @(posedge clk_sys);
            #1 chk({13'h0, pin_oen}, {13'h0, v[15:13]});
            chk({13'h0, pin_out}, 16'h0000);
            rdchk(`DTGR_ADDR_PIN, {v[15:13] & ~ext_low, 13'h0});
        end
        @(posedge clk_sys);
        ext_low <= 3'h0;
        // Offset write, then span change reloads that group; the second pass also flips span A back, reloading group A
        for (int gs = 0; gs < 2; gs++)
        begin
            v = 16'($urandom());
            wr(`DTGR_ADDR_OFS_A + 5'(gs), v);
            rdchk(`DTGR_ADDR_OFS_A + 5'(gs), v);
            @(posedge clk_sys);
            span_a <= (gs == 0);
            span_b <= (gs == 1);
            repeat (3) @(posedge clk_sys);
            #1 chk(gs ? ofs_b : ofs_a, 16'haaab);
            chk(gs ? ofs_a : ofs_b, 16'h999a);
            rdchk(`DTGR_ADDR_OFS_A + 5'(gs), 16'haaab);
        end
        // Single supply: writes ignored, reads zero
        @(posedge clk_sys);
        single <= 1'b1;
        wr(`DTGR_ADDR_OFS_A, 16'($urandom()));
        rdchk(`DTGR_ADDR_OFS_A, 16'h0000);
        rdchk(`DTGR_ADDR_OFS_B, 16'h0000);
        chk(ofs_a, 16'h0000);
        @(posedge clk_sys);
        single <= 1'b0;
        // Broadcast, then broadcast refused under correction
        v = 16'($urandom());
        wr(`DTGR_ADDR_BCAST, v);
        repeat (2) @(posedge clk_sys);
        #1 chk_all();
        latch_pulse();
        for (int i = 0; i < 8; i++)
            exp_ch[i] = v;
        chk_all();
        rdchk(`DTGR_ADDR_BCAST, 16'h0000);
        @(posedge clk_sys);
        ce <= 1'b1;
        wr(`DTGR_ADDR_BCAST, ~v);
        latch_pulse();
        chk_all();
        // Corrected path per channel, clamp corners on the first two
        for (int c = 0; c < 8; c++)
        begin
            v = 16'($urandom());
            g = 16'($urandom());
            z = 16'($urandom_range(0, 4095)) - 16'h0800;
            if (c == 0)
                {v, g, z} = {16'hffff, 16'hffff, 16'h7fff};
            if (c == 1)
                {v, g, z} = {16'h0000, 16'h0000, 16'h8000};
            wr(`DTGR_ADDR_GAIN_BASE + 5'(c), g);
            wr(`DTGR_ADDR_ZERO_BASE + 5'(c), z);
            wr(`DTGR_ADDR_IN_BASE + 5'(c), v);
            rdchk(`DTGR_ADDR_IN_BASE + 5'(c), v);
            rdchk(`DTGR_ADDR_GAIN_BASE + 5'(c), g);
            rdchk(`DTGR_ADDR_ZERO_BASE + 5'(c), z);
            latch_pulse();
            exp_ch[c] = corr(v, g, z);
            chk_all();
        end
        // Direct path: data register only, output waits for the latch
        @(posedge clk_sys);
        ce <= 1'b0;
        v = 16'($urandom());
        wr(`DTGR_ADDR_IN_BASE + 5'h3, v);
        rdchk(`DTGR_ADDR_IN_BASE + 5'h3, v);
        chk_all();
        latch_pulse();
        exp_ch[3] = v;
        chk_all();
        // Sleep: input passes straight through, wake pin clears it
        wr(`DTGR_ADDR_SLEEP, 16'h8000);
        @(posedge clk_sys);
        #1 chk({15'h0, sleep}, 16'h0001);
        for (int k = 0; k < 6; k++)
        begin
            @(posedge clk_sys);
            sdi <= 1'($urandom());
            @(posedge clk_sys);
            #1 chk({15'h0, sdo}, {15'h0, sdi});
        end
        @(posedge clk_sys);
        wake_n <= 1'b0;
        @(posedge clk_sys);
        wake_n <= 1'b1;
        #1 chk({15'h0, sleep}, 16'h0000);
        // Select-edge wake: 0, 1, 2 clock falls, then with wake disabled
        for (int n = 0; n < 4; n++)
        begin
            wr(`DTGR_ADDR_SLEEP, 16'h8000);
            @(posedge clk_sys);
            edge_en <= (n < 3);
            cs_n <= 1'b0;
            repeat (n % 3)
            begin
                @(posedge clk_sys);
                sclk_fall <= 1'b1;
                @(posedge clk_sys);
                sclk_fall <= 1'b0;
            end
            @(posedge clk_sys);
            cs_n <= 1'b1;
            repeat (2) @(posedge clk_sys);
            #1 chk({15'h0, sleep}, {15'h0, n > 1});
        end
        // Mid-run reset while asleep with pins pulled low
        wr(`DTGR_ADDR_PIN, 16'h0000);
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        #1 chk({15'h0, sleep}, 16'h0000);
        chk({13'h0, pin_oen}, 16'h0007);
        rdchk(`DTGR_ADDR_PIN, 16'he000);
        rdchk(`DTGR_ADDR_GAIN_BASE, 16'h8000);
        // Normal mode: first bit shifted in reaches the output one clock after the sixteenth fall
        @(posedge clk_sys);
        cs_n <= 1'b0;
        sdi <= 1'b1;
        sclk_fall <= 1'b1;
        repeat (16) @(posedge clk_sys);
        sclk_fall <= 1'b0;
        cs_n <= 1'b1;
        #1 chk({15'h0, sdo}, 16'h0000);
        @(posedge clk_sys);
        #1 chk({15'h0, sdo}, 16'h0001);
        wrap_up();
    end
endmodule
